// File: rtl/irqs_top.sv
// Auxiliary interrupt logic: board interrupt steering, pointer IRQ12, FPU error IRQ13.
// Assumes host I/O cycles arrive as one-cycle strobes synchronous to clk_i.
//
// Functional notes
// - Board interrupt routes to any of eleven IRQ lines by routing register.
// - Board interrupt input is active high, steered like PCI lines.
// - A routing code disables steering; board input then drives nothing.
// - Pointer function enabled takes the interrupt from the IRQ12 pointer pin.
// - Pointer interrupt raises IRQ12 internally and the CPU interrupt request.
// - In pointer mode an I/O read of 60h releases latched IRQ12.
// - In plain IRQ12 mode a read of 60h leaves IRQ12 unchanged.
// - Reads and writes of 60h still pass through to extended I/O bus.
// - Coprocessor error support works only when its enable bit is set.
// - Active FPU error raises internal IRQ13 and the CPU interrupt request.
// - I/O write to F0h negates IRQ13 and asserts ignore-numeric-error.
// - Ignore-numeric-error stays asserted until FPU error input negates.
// - Ignore-numeric-error is never active while FPU error is inactive.
// - Targets are IRQ15, 14, 12 to 9 and 7 to 3.
// - Steered inputs are synchronised to the clock before routing.
// - The one steered board input may share its IRQ line with other_irq_i.
// - Function bit 6 set selects pointer mode; clear selects plain IRQ12.
`timescale 1ns/1ps
`default_nettype none

module irqs_top
    import irqs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Host I/O cycle strobes
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    // Extended I/O bus pass-through
    output logic xio_rd_o,
    output logic xio_wr_o,
    output logic [15:0] xio_addr_o,
    // Interrupt pins
    input wire logic board_irq_in_i,
    input wire logic irq12_pointer_pin_i,
    input wire logic fpu_error_in_n_i,
    input wire logic [15:0] other_irq_i,
    // Toward the interrupt controllers and CPU
    output logic [15:0] irq_lines_o,
    output logic cpu_int_request_o,
    output logic ignore_numeric_error_out_n_o,
    // Block interrupt
    output logic irq_o
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    // True when an accepted bus write targets the given register offset.
    function automatic logic wb_hit(
        input logic wr,
        input logic [7:0] adr,
        input logic [7:0] ofs
    );
        return wr && (adr == ofs);
    endfunction

    // True when a host I/O strobe targets the given port address.
    function automatic logic io_hit(
        input logic strobe,
        input logic [15:0] addr,
        input logic [15:0] port
    );
        return strobe && (addr == port);
    endfunction

    // ****************************************************************
    // State and wiring
    // ****************************************************************
    irqs_if u_if ();

    // Register bus.
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic wb_req;
    logic wb_rd_start;
    logic wb_wr;

    // Configuration and status.
    irqs_route_t route_reg, route_next;
    logic [7:0] func_reg, func_next;
    logic [3:0] en_reg, en_next;
    logic [3:0] stat_reg, stat_next;
    logic [3:0] stat_set;
    logic [3:0] stat_clr;
    logic board_prev_reg, board_prev_next;

    // Pointer interrupt.
    logic ptr_prev_reg, ptr_prev_next;
    logic ptr_lat_reg, ptr_lat_next;
    logic ptr_mode;
    logic ptr_rise;
    logic ptr_line;
    logic kbd_rd;

    // Coprocessor error handshake.
    irqs_fpu_state_t fpu_reg, fpu_next;
    logic ign_reg, ign_next;
    logic fpu_en;
    logic fpu_error_in_n_act;
    logic fpu_clr_wr;

    // Outputs.
    irqs_lines_t lines_reg, lines_next;
    logic cpu_int_reg, cpu_int_next;
    logic irq_reg, irq_next;
    logic xio_rd_reg, xio_rd_next;
    logic xio_wr_reg, xio_wr_next;
    logic [15:0] xio_addr_reg, xio_addr_next;

    // ****************************************************************
    // Pin synchronisers and board interrupt steering
    // ****************************************************************
    irqs_steer u_steer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .board_irq_in_i(board_irq_in_i),
        .irq12_pointer_pin_i(irq12_pointer_pin_i),
        .fpu_error_in_n_i(fpu_error_in_n_i),
        .bus(u_if.front)
    );

    assign u_if.route = route_reg;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    // Ack comes one cycle after the request; writes land on the ack edge.
    always_comb begin
        wb_req = wb_cyc_i & wb_stb_i;
        wb_rd_start = wb_req & ~ack_reg;
        wb_wr = wb_req & ack_reg & wb_we_i & wb_sel_i[0];
        ack_next = wb_req & ~ack_reg;
        dat_next = dat_reg;
        if (wb_rd_start) begin
            case (wb_adr_i)
                `IRQS_OFS_ROUTE: dat_next = {28'h000_0000, route_reg};
                `IRQS_OFS_FUNC: dat_next = {24'h00_0000, func_reg};
                `IRQS_OFS_LINES: dat_next = {16'h0000, lines_reg};
                `IRQS_OFS_STAT: dat_next = {28'h000_0000, stat_reg};
                `IRQS_OFS_EN: dat_next = {28'h000_0000, en_reg};
                default: dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // ****************************************************************
    // Configuration and status registers
    // ****************************************************************
    // Status bits are sticky; a hardware set beats a clear in the same cycle.
    always_comb begin
        route_next = route_reg;
        func_next = func_reg;
        en_next = en_reg;
        if (wb_hit(wb_wr, wb_adr_i, `IRQS_OFS_ROUTE)) begin
            route_next = wb_dat_i[3:0];
        end
        if (wb_hit(wb_wr, wb_adr_i, `IRQS_OFS_FUNC)) begin
            func_next = wb_dat_i[7:0];
        end
        if (wb_hit(wb_wr, wb_adr_i, `IRQS_OFS_EN)) begin
            en_next = wb_dat_i[3:0];
        end
        board_prev_next = u_if.board_sync;
        stat_set = 4'h0;
        stat_set[`IRQS_ST_PTR_BIT] = ptr_rise & ptr_mode;
        stat_set[`IRQS_ST_FPU_BIT] = u_if.fpu_err_sync & fpu_en;
        stat_set[`IRQS_ST_BOARD_BIT] = u_if.board_sync & ~board_prev_reg;
        stat_set[`IRQS_ST_IGN_BIT] = ign_next & ~ign_reg;
        if (wb_hit(wb_wr, wb_adr_i, `IRQS_OFS_CLR)) begin
            stat_clr = wb_dat_i[3:0];
        end else begin
            stat_clr = 4'h0;
        end
        stat_next = (stat_reg & ~stat_clr) | stat_set;
        irq_next = |(stat_reg & en_reg);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_reg <= `IRQS_ROUTE_RST;
            func_reg <= `IRQS_FUNC_RST;
            en_reg <= `IRQS_EN_RST;
            stat_reg <= 4'h0;
            board_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            route_reg <= route_next;
            func_reg <= func_next;
            en_reg <= en_next;
            stat_reg <= stat_next;
            board_prev_reg <= board_prev_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************************************
    // Pointer interrupt on IRQ12
    // ****************************************************************
    // The edge detector resets low, the idle level of the pin, so reset
    // release makes no false edge.
    always_comb begin
        ptr_mode = func_reg[`IRQS_FUNC_PTR_BIT];
        kbd_rd = io_hit(io_rd_i, io_addr_i, `IRQS_IO_KBD_DATA);
        ptr_rise = u_if.ptr_sync & ~ptr_prev_reg;
        ptr_prev_next = u_if.ptr_sync;
        ptr_lat_next = ptr_lat_reg;
        if (!ptr_mode) begin
            ptr_lat_next = 1'b0;
        end else if (ptr_rise) begin
            ptr_lat_next = 1'b1;
        end else if (kbd_rd) begin
            ptr_lat_next = 1'b0;
        end
        // Plain mode passes the pin through, untouched by port reads.
        if (ptr_mode) begin
            ptr_line = ptr_lat_reg;
        end else begin
            ptr_line = u_if.ptr_sync;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_prev_reg <= 1'b0;
            ptr_lat_reg <= 1'b0;
        end else begin
            ptr_prev_reg <= ptr_prev_next;
            ptr_lat_reg <= ptr_lat_next;
        end
    end

    // ****************************************************************
    // Coprocessor error and ignore handshake
    // ****************************************************************
    // The raw error pin drives this machine so the ignore output can
    // follow it without synchroniser lag.
    always_comb begin
        fpu_en = func_reg[`IRQS_FUNC_FPU_BIT];
        fpu_error_in_n_act = ~fpu_error_in_n_i;
        fpu_clr_wr = io_hit(io_wr_i, io_addr_i, `IRQS_IO_FPU_CLR);
        fpu_next = fpu_reg;
        case (fpu_reg)
            FPU_IDLE: begin
                if (fpu_en && fpu_error_in_n_act) begin
                    fpu_next = FPU_REQ;
                end
            end
            FPU_REQ: begin
                if (!fpu_error_in_n_act || !fpu_en) begin
                    fpu_next = FPU_IDLE;
                end else if (fpu_clr_wr) begin
                    fpu_next = FPU_IGN;
                end
            end
            FPU_IGN: begin
                if (!fpu_error_in_n_act) begin
                    fpu_next = FPU_IDLE;
                end
            end
            default: begin
                fpu_next = FPU_IDLE;
            end
        endcase
        ign_next = (fpu_next == FPU_IGN);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fpu_reg <= FPU_IDLE;
            ign_reg <= 1'b0;
        end else begin
            fpu_reg <= fpu_next;
            ign_reg <= ign_next;
        end
    end

    // ****************************************************************
    // IRQ lines, CPU request and I/O pass-through
    // ****************************************************************
    always_comb begin
        lines_next = other_irq_i | u_if.steered;
        lines_next[12] = lines_next[12] | ptr_line;
        lines_next[13] = lines_next[13] | (fpu_reg == FPU_REQ);
        cpu_int_next = |lines_next;
        xio_rd_next = io_rd_i;
        xio_wr_next = io_wr_i;
        xio_addr_next = io_addr_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines_reg <= 16'h0000;
            cpu_int_reg <= 1'b0;
            xio_rd_reg <= 1'b0;
            xio_wr_reg <= 1'b0;
            xio_addr_reg <= 16'h0000;
        end else begin
            lines_reg <= lines_next;
            cpu_int_reg <= cpu_int_next;
            xio_rd_reg <= xio_rd_next;
            xio_wr_reg <= xio_wr_next;
            xio_addr_reg <= xio_addr_next;
        end
    end

    // ****************************************************************
    // Output drive
    // ****************************************************************
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign xio_rd_o = xio_rd_reg;
    assign xio_wr_o = xio_wr_reg;
    assign xio_addr_o = xio_addr_reg;
    assign irq_lines_o = lines_reg;
    assign cpu_int_request_o = cpu_int_reg;
    assign irq_o = irq_reg;

    // Gated by the live pin so ignore drops the moment the error clears.
    assign ignore_numeric_error_out_n_o = ~(ign_reg & fpu_error_in_n_act);

endmodule // irqs_top
`default_nettype wire

// File: rtl/irqs_map.svh
// Offsets, field positions, codes and reset values of the interrupt steering block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef IRQS_MAP_SVH
`define IRQS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IRQS_OFS_ROUTE 8'h00
`define IRQS_OFS_FUNC 8'h04
`define IRQS_OFS_LINES 8'h08
`define IRQS_OFS_STAT 8'h0C
`define IRQS_OFS_CLR 8'h10
`define IRQS_OFS_EN 8'h14

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define IRQS_FUNC_PTR_BIT 6
`define IRQS_FUNC_FPU_BIT 0
`define IRQS_ST_PTR_BIT 0
`define IRQS_ST_FPU_BIT 1
`define IRQS_ST_BOARD_BIT 2
`define IRQS_ST_IGN_BIT 3
`define IRQS_ROUTE_RST 4'h0
`define IRQS_FUNC_RST 8'h00
`define IRQS_EN_RST 4'h0

// ****************************************************************
// Decoded host I/O addresses
// ****************************************************************
`define IRQS_IO_KBD_DATA 16'h0060
`define IRQS_IO_FPU_CLR 16'h00F0

// ****************************************************************
// Routing codes: zero and 12 to 15 disable routing
// ****************************************************************
`define IRQS_RT_IRQ3 4'h1
`define IRQS_RT_IRQ4 4'h2
`define IRQS_RT_IRQ5 4'h3
`define IRQS_RT_IRQ6 4'h4
`define IRQS_RT_IRQ7 4'h5
`define IRQS_RT_IRQ9 4'h6
`define IRQS_RT_IRQ10 4'h7
`define IRQS_RT_IRQ11 4'h8
`define IRQS_RT_IRQ12 4'h9
`define IRQS_RT_IRQ14 4'hA
`define IRQS_RT_IRQ15 4'hB

`endif

// File: rtl/irqs_pkg.sv
// Types and the routing decode shared by the interrupt steering block.
// Assumes irqs_map.svh is on the include path.
`include "irqs_map.svh"

package irqs_pkg;

    typedef logic [3:0] irqs_route_t;
    typedef logic [15:0] irqs_lines_t;

    typedef enum logic [1:0] {
        FPU_IDLE,
        FPU_REQ,
        FPU_IGN
    } irqs_fpu_state_t;

    // Turns a routing code into a one-hot IRQ vector, all zero when disabled.
    function automatic irqs_lines_t irqs_route_decode(input irqs_route_t code);
        irqs_lines_t v;
        v = 16'h0000;
        case (code)
            `IRQS_RT_IRQ3: v[3] = 1'b1;
            `IRQS_RT_IRQ4: v[4] = 1'b1;
            `IRQS_RT_IRQ5: v[5] = 1'b1;
            `IRQS_RT_IRQ6: v[6] = 1'b1;
            `IRQS_RT_IRQ7: v[7] = 1'b1;
            `IRQS_RT_IRQ9: v[9] = 1'b1;
            `IRQS_RT_IRQ10: v[10] = 1'b1;
            `IRQS_RT_IRQ11: v[11] = 1'b1;
            `IRQS_RT_IRQ12: v[12] = 1'b1;
            `IRQS_RT_IRQ14: v[14] = 1'b1;
            `IRQS_RT_IRQ15: v[15] = 1'b1;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

endpackage

// File: rtl/irqs_if.sv
// Signals between the steering front end and the top of the block.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
`default_nettype none

interface irqs_if;
    import irqs_pkg::*;
    irqs_route_t route;
    logic board_sync;
    logic ptr_sync;
    logic fpu_err_sync;
    irqs_lines_t steered;

    modport front (input route, output board_sync, output ptr_sync, output fpu_err_sync,
        output steered);
    modport core (output route, input board_sync, input ptr_sync, input fpu_err_sync,
        input steered);
endinterface

`default_nettype wire

// File: rtl/irqs_steer.sv
// Synchronises the raw interrupt pins and steers the board interrupt.
// Assumes the pins may be asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module irqs_steer
    import irqs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw pins
    input wire logic board_irq_in_i,
    input wire logic irq12_pointer_pin_i,
    input wire logic fpu_error_in_n_i,
    // Core side
    irqs_if.front bus
);

    logic [2:0] s1_reg, s1_next;
    logic [2:0] s2_reg, s2_next;

    // ****************************************************************
    // Two-stage synchronisers
    // ****************************************************************
    always_comb begin
        s1_next = {~fpu_error_in_n_i, irq12_pointer_pin_i, board_irq_in_i};
        s2_next = s1_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign bus.board_sync = s2_reg[0];
    assign bus.ptr_sync = s2_reg[1];
    assign bus.fpu_err_sync = s2_reg[2];

    // Active-high board request onto the selected line, nothing when disabled.
    assign bus.steered = s2_reg[0] ? irqs_route_decode(bus.route) : 16'h0000;

endmodule // irqs_steer

`default_nettype wire

// File: sim/irqs_asserts.sv
// Checker for the irqs_top ports.
// Assumes the function register is written over Wishbone only.
`timescale 1ns/1ps
`default_nettype none
module irqs_chk (
    input wire logic clk_i, rst_i, wb_stb_i, wb_we_i, wb_ack_o, io_rd_i, io_wr_i,
    input wire logic xio_rd_o, irq12_pointer_pin_i, fpu_error_in_n_i, cpu_int_request_o,
    input wire logic ignore_numeric_error_out_n_o,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [15:0] io_addr_i, xio_addr_o, irq_lines_o
);
    logic fe_reg, pe_reg;
    wire ign = !ignore_numeric_error_out_n_o;
    wire fpu_error_in_n = !fpu_error_in_n_i;
    always_ff @(posedge clk_i)
        if (rst_i) {fe_reg, pe_reg} <= 2'b00;
        else if (wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h04)
            {fe_reg, pe_reg} <= {wb_dat_i[0], wb_dat_i[6]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rd60_s;
        io_rd_i && io_addr_i == 16'h0060;
    endsequence
    ack_a: assert property (wb_stb_i |-> ##[0:3] wb_ack_o) else $error("no ack");
    ign_cause_a: assert property ($rose(ign) |-> fpu_error_in_n) else $error("bad ignore");
    ign_hold_a: assert property ($fell(ign) |-> !fpu_error_in_n) else $error("drop");
    ign_set_a: assert property (fe_reg && io_wr_i && io_addr_i == 16'h00F0 && fpu_error_in_n
        && $past(fpu_error_in_n, 4) |-> ##[1:3] ign) else $error("no ignore");
    fpu_int_a: assert property (fe_reg && $rose(fpu_error_in_n) |-> ##[1:6] cpu_int_request_o)
        else $error("no fpu int");
    ptr_int_a: assert property (pe_reg && $rose(irq12_pointer_pin_i)
        |-> ##[1:6] irq_lines_o[12] && cpu_int_request_o) else $error("no ptr int");
    ptr_rel_a: assert property (rd60_s ##0 (pe_reg && !irq12_pointer_pin_i
        && !$past(irq12_pointer_pin_i, 4)) |-> ##[1:6] !irq_lines_o[12]) else $error("held");
    plain_a: assert property (!pe_reg && irq12_pointer_pin_i && $past(irq12_pointer_pin_i, 4)
        |-> irq_lines_o[12]) else $error("no irq12");
    pass_a: assert property (rd60_s |-> ##[0:2] xio_rd_o && xio_addr_o == 16'h0060)
        else $error("no pass");
endmodule // irqs_chk
bind irqs_top irqs_chk u_chk (.*);
`default_nettype wire

// File: sim/irqs_cpu_model.sv
// CPU error pin model: asserts on request, negates lag cycles after ignore is seen.
// Assumes the block's clock.
`timescale 1ns/1ps
`default_nettype none
module irqs_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raise_i,
    input wire logic [3:0] lag_i,
    input wire logic ign_n_i,
    output logic fpu_error_in_n_n_o
);
    logic [3:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) fpu_error_in_n_n_o <= 1'b1;
        else if (raise_i) fpu_error_in_n_n_o <= 1'b0;
        else if (!ign_n_i && cnt_reg == lag_i) fpu_error_in_n_n_o <= 1'b1;
        cnt_reg <= (!ign_n_i && !fpu_error_in_n_n_o) ? cnt_reg + 4'h1 : 4'h0;
    end
endmodule // irqs_cpu_model
`default_nettype wire

// File: sim/tb.sv
// Bench for irqs_top: steering, pointer IRQ12, FPU error, status interrupt.
// Assumes the checker binds itself to irqs_top.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, io_rd_i, io_wr_i, raise;
    logic board_irq_in_i, irq12_pointer_pin_i, fpu_error_in_n_i, wb_ack_o, xio_rd_o, xio_wr_o;
    logic cpu_int_request_o, ignore_numeric_error_out_n_o, irq_o;
    logic [3:0] wb_sel_i = 4'hF, lag;
    logic [7:0] wb_adr_i;
    logic [15:0] io_addr_i, other_irq_i, xio_addr_o, irq_lines_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int errors = 0, samples_checked = 0, ticks = 0, seed = 32'hf738;
    irqs_top dut (.*);
    irqs_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .lag_i(lag),
        .ign_n_i(ignore_numeric_error_out_n_o), .fpu_error_in_n_n_o(fpu_error_in_n_i));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++ticks == 5000) begin errors++; final_report(); end
    task automatic final_report();
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end
    endtask
    task automatic cy(input int n); repeat (n) @(posedge clk_i); endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic io(input logic r, input logic [15:0] a);
        @(posedge clk_i);
        {io_rd_i, io_wr_i, io_addr_i} <= {r, !r, a};
        @(posedge clk_i);
        {io_rd_i, io_wr_i} <= 2'b00;
    endtask
    function automatic logic [15:0] route_exp(input logic [3:0] c);
        int map [11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
        return (c >= 4'h1 && c <= 4'hB) ? 16'h0001 << map[c - 1] : 16'h0000;
    endfunction
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, io_rd_i, io_wr_i, raise, board_irq_in_i} = '0;
        {irq12_pointer_pin_i, lag, wb_adr_i, io_addr_i, other_irq_i, wb_dat_i} = '0;
        cy(4);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk("route_rst", 32'h0, rd);
        wb(1'b0, 8'h1C, 32'h0);
        for (int c = 0; c < 16; c++) begin
            other_irq_i <= 16'($random(seed)) & 16'hCFFF;
            wb(1'b1, 8'h00, 32'(c));
            board_irq_in_i <= 1'b1;
            cy(5);
            chk("steer_on", route_exp(4'(c)) | other_irq_i, irq_lines_o);
            board_irq_in_i <= 1'b0;
            cy(5);
            chk("steer_off", other_irq_i, irq_lines_o);
        end
        other_irq_i <= 16'h0000;
        wb(1'b1, 8'h04, 32'h0000_0041);
        irq12_pointer_pin_i <= 1'b1;
        cy(6);
        irq12_pointer_pin_i <= 1'b0;
        cy(6);
        chk("ptr_irq", 32'h3, {irq_lines_o[12], cpu_int_request_o});
        io(1'b1, 16'h0060);
        io(1'b0, 16'h0060);
        cy(6);
        chk("ptr_rel", 32'h0, irq_lines_o[12]);
        wb(1'b1, 8'h04, 32'h0000_0001);
        irq12_pointer_pin_i <= 1'b1;
        io(1'b1, 16'h0060);
        cy(5);
        chk("plain", 32'h1, irq_lines_o[12]);
        irq12_pointer_pin_i <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            lag <= 4'(k * 5);
            raise <= 1'b1;
            cy(1);
            raise <= 1'b0;
            cy(6);
            chk("fpu_int", 32'h3, {cpu_int_request_o, ignore_numeric_error_out_n_o});
            io(1'b0, 16'h00F0);
            cy(14);
            chk("fpu_done", 32'h1, {cpu_int_request_o, ignore_numeric_error_out_n_o});
        end
        wb(1'b0, 8'h0C, 32'h0);
        chk("stat", 32'h2, rd & 32'h2);
        chk("irq_mask", 32'h0, irq_o);
        wb(1'b1, 8'h14, 32'h0000_0002);
        cy(2);
        chk("irq_on", 32'h1, irq_o);
        wb(1'b1, 8'h10, 32'h0000_0002);
        cy(2);
        chk("irq_off", 32'h0, irq_o);
        final_report();
    end
endmodule // tb
`default_nettype wire
